/* File: rtl/flag_pkg.sv */
// constants and types shared by the flag update unit
`default_nettype none
package flag_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NFLAG = 4;
  // flag bit positions
  localparam int unsigned FZ = 0;
  localparam int unsigned FC = 1;
  localparam int unsigned FAC = 2;
  localparam int unsigned FOV = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] ACC_RST = 8'h00;
  // update masks, one bit per flag
  localparam logic [3:0] MASK_ALL = 4'hf;
  localparam logic [3:0] MASK_C = 4'h2;
  localparam logic [3:0] MASK_Z = 4'h1;
  localparam logic [3:0] MASK_NONE = 4'h0;
  // last data ram byte open to single-bit access
  localparam logic [7:0] BIT_RAM_LAST = 8'h3f;
  localparam logic [7:0] ZERO_B = 8'h00;
  localparam logic [7:0] ONES_B = 8'hff;
  localparam logic [3:0] NIB_MASK = 4'hf;
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_INC, OP_DEC,
    OP_CEQSN, OP_CNEQSN, OP_IZSN, OP_DZSN, OP_NADD, OP_COMP,
    OP_SR, OP_SRC, OP_SL, OP_SLC,
    OP_AND, OP_OR, OP_XOR, OP_XOR_IO, OP_NOT, OP_NEG,
    OP_LD_MEM, OP_LD_IMM, OP_STORE, OP_XCH, OP_CLEAR, OP_SWAP,
    OP_PUSHAF, OP_POPAF, OP_SWAPC,
    OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_LOW, OP_SKIP_HIGH,
    OP_CTRL, OP_ENGINT, OP_DISGINT, OP_RETI
  } op_t;
endpackage : flag_pkg
`default_nettype wire

/* File: rtl/alu_if.sv */
// operand and result bundle between the flag unit and its adder
`default_nettype none
interface alu_if;
  flag_pkg::op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] res;
  logic [3:0] flg;
  modport user (output op, a, b, cin, input res, flg);
  modport core (input op, a, b, cin, output res, flg);
endinterface : alu_if
`default_nettype wire

/* File: rtl/alu_core.sv */
// combinational 8-bit adder, shifter and logic unit with flag outputs
`default_nettype none
module alu_core (
  alu_if.core bus
);
  logic [7:0] x;
  logic [7:0] y;
  logic ci;
  logic inv;
  logic [8:0] s;
  logic [4:0] n;
  logic [7:0] r;
  logic c;
  // subtraction runs as x + ~y + 1; carry then reads as borrow
  always_comb begin
    x = bus.a;
    y = bus.b;
    ci = 1'b0;
    inv = 1'b0;
    unique case (bus.op)
      flag_pkg::OP_ADDC: ci = bus.cin;
      flag_pkg::OP_SUB, flag_pkg::OP_CEQSN, flag_pkg::OP_CNEQSN,
      flag_pkg::OP_COMP: begin
        y = ~bus.b;
        ci = 1'b1;
        inv = 1'b1;
      end
      flag_pkg::OP_SUBC: begin
        y = ~bus.b;
        ci = ~bus.cin;
        inv = 1'b1;
      end
      flag_pkg::OP_INC, flag_pkg::OP_IZSN: begin
        x = bus.b;
        y = flag_pkg::ZERO_B;
        ci = 1'b1;
      end
      flag_pkg::OP_DEC, flag_pkg::OP_DZSN: begin
        x = bus.b;
        y = flag_pkg::ONES_B;
        inv = 1'b1;
      end
      flag_pkg::OP_NADD: begin
        x = bus.b;
        y = ~bus.a;
        ci = 1'b1;
        inv = 1'b1;
      end
      // negate acts on the operand, not the accumulator
      flag_pkg::OP_NEG: begin
        x = flag_pkg::ZERO_B;
        y = ~bus.b;
        ci = 1'b1;
        inv = 1'b1;
      end
      default: ;
    endcase
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    r = s[7:0];
    c = s[8] ^ inv;
    unique case (bus.op)
      flag_pkg::OP_SR: {r, c} = {1'b0, bus.b};
      flag_pkg::OP_SRC: {r, c} = {bus.cin, bus.b};
      flag_pkg::OP_SL: {c, r} = {bus.b, 1'b0};
      flag_pkg::OP_SLC: {c, r} = {bus.b, bus.cin};
      flag_pkg::OP_AND: r = bus.a & bus.b;
      flag_pkg::OP_OR: r = bus.a | bus.b;
      flag_pkg::OP_XOR, flag_pkg::OP_XOR_IO: r = bus.a ^ bus.b;
      flag_pkg::OP_NOT: r = ~bus.b;
      flag_pkg::OP_LD_MEM, flag_pkg::OP_LD_IMM, flag_pkg::OP_XCH,
      flag_pkg::OP_STORE: r = bus.b;
      flag_pkg::OP_SWAP: r = {bus.a[3:0], bus.a[7:4]};
      default: ;
    endcase
    bus.res = r;
    bus.flg[flag_pkg::FZ] = (r == flag_pkg::ZERO_B);
    bus.flg[flag_pkg::FC] = c;
    bus.flg[flag_pkg::FAC] = n[4] ^ inv;
    bus.flg[flag_pkg::FOV] = (x[7] == y[7]) && (s[7] != x[7]);
  end
endmodule : alu_core
`default_nettype wire

/* File: rtl/gint_ctrl.sv */
// global interrupt enable with save on entry and restore on return
`default_nettype none
module gint_ctrl (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_enable,
  input wire logic i_disable,
  input wire logic i_take,
  input wire logic i_ret,
  output logic o_gie
);
  logic gie_ff;
  logic saved_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      gie_ff <= 1'b0;
    end else if (i_take) begin
      gie_ff <= 1'b0;
    end else if (i_ret) begin
      gie_ff <= saved_ff;
    end else if (i_enable || i_disable) begin
      gie_ff <= i_enable;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      saved_ff <= 1'b0;
    end else if (i_take) begin
      saved_ff <= gie_ff;
    end
  end
  assign o_gie = gie_ff;
endmodule : gint_ctrl
`default_nettype wire

/* File: rtl/alu_flag_update.sv */
// flag register, result path and interrupt gate of the 8-bit core
`default_nettype none
// Behaviour
// - add and subtract forms update all four flags
// - memory increment and decrement update all flags
// - compare-skip instructions set flags like subtraction
// - increment/decrement-and-skip update all four flags
// - negated add and compare update all flags
// - shifts and rotates change only carry
// - and, or, xor, not, negate change zero only
// - xor into io register changes no flag
// - load from memory sets zero only
// - moves, exchange, clear, swap leave flags alone
// - flag restore overwrites all four flags
// - io bit swap changes carry only
// - bit set, clear, test leave flags alone
// - flow control and system ops keep flags
// - ram bit access limited to low addresses
// - push and pop of accumulator with flags
// - interrupt return restores global enable
// - global enable gates every interrupt
module alu_flag_update #(
  parameter int unsigned DATA_W = flag_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire flag_pkg::op_t i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic [7:0] i_bit_addr,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_bit_ram,
  input wire logic i_io_bit,
  input wire logic [7:0] i_pop_acc,
  input wire logic [3:0] i_pop_flags,
  input wire logic i_irq_req,
  output logic [3:0] o_flags,
  output logic [7:0] o_result,
  output logic o_result_we,
  output logic o_skip,
  output logic o_bit_err,
  output logic o_io_bit,
  output logic o_push_valid,
  output logic [11:0] o_push_data,
  output logic o_irq_take,
  output logic o_gie
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("alu_flag_update serves an 8-bit datapath only");
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  alu_if alu ();
  logic [3:0] flags_ff;
  logic [3:0] mask;
  logic [3:0] nxt_flags;
  logic bit_ok;
  logic bit_val;
  logic bit_op;
  logic res_we;
  logic skip;
  logic gie;
  logic take;

  assign alu.op = i_op;
  assign alu.a = i_a;
  assign alu.b = i_b;
  assign alu.cin = flags_ff[flag_pkg::FC];

  alu_core u_alu (
    .bus(alu)
  );

  assign bit_op = (i_op == flag_pkg::OP_BIT_SET)
    || (i_op == flag_pkg::OP_BIT_CLEAR)
    || (i_op == flag_pkg::OP_SKIP_LOW)
    || (i_op == flag_pkg::OP_SKIP_HIGH);
  // ram bit ops above the low window are dropped, io bits always pass
  assign bit_ok = !i_bit_ram || (i_bit_addr <= flag_pkg::BIT_RAM_LAST);
  assign bit_val = i_b[i_bit_sel];

  // ----------------------------------------------------------------
  // which flags each class writes
  // ----------------------------------------------------------------
  always_comb begin
    unique case (i_op)
      flag_pkg::OP_ADD, flag_pkg::OP_ADDC, flag_pkg::OP_SUB,
      flag_pkg::OP_SUBC: mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_INC, flag_pkg::OP_DEC: mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_CEQSN, flag_pkg::OP_CNEQSN:
        mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_IZSN, flag_pkg::OP_DZSN:
        mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_NADD, flag_pkg::OP_COMP: mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_SR, flag_pkg::OP_SRC, flag_pkg::OP_SL,
      flag_pkg::OP_SLC: mask = flag_pkg::MASK_C;
      flag_pkg::OP_AND, flag_pkg::OP_OR, flag_pkg::OP_XOR,
      flag_pkg::OP_NOT, flag_pkg::OP_NEG: mask = flag_pkg::MASK_Z;
      flag_pkg::OP_XOR_IO: mask = flag_pkg::MASK_NONE;
      flag_pkg::OP_LD_MEM: mask = flag_pkg::MASK_Z;
      flag_pkg::OP_LD_IMM, flag_pkg::OP_STORE, flag_pkg::OP_XCH,
      flag_pkg::OP_CLEAR, flag_pkg::OP_SWAP,
      flag_pkg::OP_PUSHAF: mask = flag_pkg::MASK_NONE;
      flag_pkg::OP_POPAF: mask = flag_pkg::MASK_ALL;
      flag_pkg::OP_SWAPC: mask = flag_pkg::MASK_C;
      flag_pkg::OP_BIT_SET, flag_pkg::OP_BIT_CLEAR,
      flag_pkg::OP_SKIP_LOW,
      flag_pkg::OP_SKIP_HIGH: mask = flag_pkg::MASK_NONE;
      default: mask = flag_pkg::MASK_NONE;
    endcase
  end

  always_comb begin
    nxt_flags = alu.flg;
    if (i_op == flag_pkg::OP_POPAF) begin
      nxt_flags = i_pop_flags;
    end else if (i_op == flag_pkg::OP_SWAPC) begin
      nxt_flags[flag_pkg::FC] = i_io_bit;
    end
    // masked bits hold their old value
    nxt_flags = (mask & nxt_flags) | (~mask & flags_ff);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      flags_ff <= flag_pkg::FLAGS_RST;
    end else if (i_valid && !take) begin
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------
  // result, skip and bit handling
  // ----------------------------------------------------------------
  always_comb begin
    res_we = 1'b0;
    skip = 1'b0;
    unique case (i_op)
      flag_pkg::OP_CEQSN: skip = alu.flg[flag_pkg::FZ];
      flag_pkg::OP_CNEQSN: skip = !alu.flg[flag_pkg::FZ];
      flag_pkg::OP_IZSN, flag_pkg::OP_DZSN: begin
        res_we = 1'b1;
        skip = alu.flg[flag_pkg::FZ];
      end
      flag_pkg::OP_SKIP_LOW: skip = bit_ok && !bit_val;
      flag_pkg::OP_SKIP_HIGH: skip = bit_ok && bit_val;
      flag_pkg::OP_BIT_SET, flag_pkg::OP_BIT_CLEAR:
        res_we = bit_ok;
      flag_pkg::OP_COMP, flag_pkg::OP_PUSHAF, flag_pkg::OP_SWAPC,
      flag_pkg::OP_NOP, flag_pkg::OP_CTRL, flag_pkg::OP_ENGINT,
      flag_pkg::OP_DISGINT, flag_pkg::OP_RETI: res_we = 1'b0;
      default: res_we = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result <= flag_pkg::ACC_RST;
    end else if (i_valid && !take) begin
      if (i_op == flag_pkg::OP_POPAF) begin
        o_result <= i_pop_acc;
      end else if (i_op == flag_pkg::OP_CLEAR) begin
        o_result <= flag_pkg::ZERO_B;
      end else if (i_op == flag_pkg::OP_BIT_SET) begin
        o_result <= i_b | (8'h01 << i_bit_sel);
      end else if (i_op == flag_pkg::OP_BIT_CLEAR) begin
        o_result <= i_b & ~(8'h01 << i_bit_sel);
      end else begin
        o_result <= alu.res;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result_we <= 1'b0;
      o_skip <= 1'b0;
      o_bit_err <= 1'b0;
    end else begin
      o_result_we <= i_valid && !take && res_we;
      o_skip <= i_valid && !take && skip;
      o_bit_err <= i_valid && !take && bit_op && !bit_ok;
    end
  end

  // old carry goes out to the io bit on a swap
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_io_bit <= 1'b0;
    end else if (i_valid && !take && i_op == flag_pkg::OP_SWAPC) begin
      o_io_bit <= flags_ff[flag_pkg::FC];
    end
  end

  // ----------------------------------------------------------------
  // save of accumulator and flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_push_valid <= 1'b0;
      o_push_data <= 12'h000;
    end else begin
      o_push_valid <= i_valid && !take && i_op == flag_pkg::OP_PUSHAF;
      if (i_valid && !take && i_op == flag_pkg::OP_PUSHAF) begin
        o_push_data <= {flags_ff, i_a};
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt gate
  // ----------------------------------------------------------------
  // a taken interrupt pre-empts the instruction offered in that cycle
  assign take = i_valid && i_irq_req && gie;

  gint_ctrl u_gint (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_enable(i_valid && !take && i_op == flag_pkg::OP_ENGINT),
    .i_disable(i_valid && !take && i_op == flag_pkg::OP_DISGINT),
    .i_take(take),
    .i_ret(i_valid && !take && i_op == flag_pkg::OP_RETI),
    .o_gie(gie)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_irq_take <= 1'b0;
      o_gie <= 1'b0;
    end else begin
      o_irq_take <= take;
      o_gie <= gie;
    end
  end

  assign o_flags = flags_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  logic go;
  assign go = i_valid && !take;

  sequence s_shift;
    go && (i_op inside {flag_pkg::OP_SR, flag_pkg::OP_SRC,
      flag_pkg::OP_SL, flag_pkg::OP_SLC});
  endsequence

  sequence s_logic;
    go && (i_op inside {flag_pkg::OP_AND, flag_pkg::OP_OR,
      flag_pkg::OP_XOR, flag_pkg::OP_NOT, flag_pkg::OP_NEG});
  endsequence

  a_add_flags: assert property (go && i_op == flag_pkg::OP_ADD |=>
    flags_ff[flag_pkg::FC] == $past({1'b0, i_a} + {1'b0, i_b}) >> 8)
    else $error("add carry wrong");
  a_inc_zero: assert property (go && i_op == flag_pkg::OP_INC
    && i_b == flag_pkg::ONES_B |=> flags_ff[flag_pkg::FZ]
    && flags_ff[flag_pkg::FC])
    else $error("increment wrap flags wrong");
  a_ceq_skip: assert property (go && i_op == flag_pkg::OP_CEQSN
    && i_a == i_b |=> o_skip && flags_ff[flag_pkg::FZ] && !o_result_we)
    else $error("compare equal did not skip");
  a_dzsn_skip: assert property (go && i_op == flag_pkg::OP_DZSN
    && i_b == 8'h01 |=> o_skip && o_result == flag_pkg::ZERO_B)
    else $error("decrement to zero did not skip");
  a_comp_nowr: assert property (go && i_op == flag_pkg::OP_COMP |=>
    !o_result_we)
    else $error("compare wrote a result");
  a_shift_keep: assert property (s_shift |=>
    o_flags[flag_pkg::FZ] == $past(o_flags[flag_pkg::FZ])
    && o_flags[flag_pkg::FAC] == $past(o_flags[flag_pkg::FAC])
    && o_flags[flag_pkg::FOV] == $past(o_flags[flag_pkg::FOV]))
    else $error("shift touched a non-carry flag");
  a_logic_zonly: assert property (s_logic |=>
    o_flags[3:1] == $past(o_flags[3:1]))
    else $error("logic op touched carry, ac or ov");
  a_xorio_keep: assert property (go && i_op == flag_pkg::OP_XOR_IO |=>
    $stable(o_flags))
    else $error("io xor changed flags");
  a_load_zero: assert property (go && i_op == flag_pkg::OP_LD_MEM |=>
    o_flags[flag_pkg::FZ] == (o_result == flag_pkg::ZERO_B))
    else $error("load zero flag wrong");
  a_pop_flags: assert property (go && i_op == flag_pkg::OP_POPAF |=>
    o_flags == $past(i_pop_flags) && o_result == $past(i_pop_acc))
    else $error("restore did not load flags");
  a_bit_range: assert property (go && bit_op && i_bit_ram
    && i_bit_addr > flag_pkg::BIT_RAM_LAST |=> o_bit_err
    && !o_result_we && !o_skip)
    else $error("out of range bit access acted");
  a_push_pair: assert property (go && i_op == flag_pkg::OP_PUSHAF |=>
    o_push_valid && o_push_data == {$past(flags_ff), $past(i_a)})
    else $error("push data wrong");
  a_gie_block: assert property (!gie |=> !o_irq_take)
    else $error("interrupt taken while disabled");

  // an entered interrupt not yet left; bounds nothing, so no long window
  logic in_isr_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      in_isr_ff <= 1'b0;
    end else if (take) begin
      in_isr_ff <= 1'b1;
    end else if (go && i_op == flag_pkg::OP_RETI) begin
      in_isr_ff <= 1'b0;
    end
  end

  a_reti_gie: assert property (in_isr_ff && go
    && i_op == flag_pkg::OP_RETI |=> gie)
    else $error("return did not restore global enable");

endmodule : alu_flag_update
`default_nettype wire

/* File: bench/alu_flag_update_test.sv */
// self-checking bench for the flag update unit
`default_nettype none
module alu_flag_update_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NOPS = 40;
  logic i_clk, i_rstn, i_valid, i_bit_ram, i_io_bit, i_irq_req;
  flag_pkg::op_t i_op;
  logic [7:0] i_a, i_b, i_bit_addr, i_pop_acc;
  logic [2:0] i_bit_sel;
  logic [3:0] i_pop_flags, o_flags, exp_f;
  logic [7:0] o_result;
  logic [11:0] o_push_data;
  logic o_result_we, o_skip, o_bit_err, o_io_bit;
  logic o_push_valid, o_irq_take, o_gie;
  logic [31:0] seed, r1, r2;
  logic [7:0] ca [5] = '{8'h80, 8'h0f, 8'h00, 8'hff, 8'h7f};
  logic [7:0] cb [5] = '{8'h80, 8'h01, 8'h00, 8'h01, 8'h01};
  int err_count, tests_run;

  alu_flag_update i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op),
    .i_a(i_a), .i_b(i_b), .i_bit_addr(i_bit_addr), .i_bit_sel(i_bit_sel),
    .i_bit_ram(i_bit_ram), .i_io_bit(i_io_bit), .i_pop_acc(i_pop_acc),
    .i_pop_flags(i_pop_flags), .i_irq_req(i_irq_req), .o_flags(o_flags),
    .o_result(o_result), .o_result_we(o_result_we), .o_skip(o_skip),
    .o_bit_err(o_bit_err), .o_io_bit(o_io_bit),
    .o_push_valid(o_push_valid), .o_push_data(o_push_data),
    .o_irq_take(o_irq_take), .o_gie(o_gie)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // reference model and helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // returns {write, result, bit_err, skip, flags}
  function automatic logic [14:0] model(input flag_pkg::op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [3:0] f);
    logic [7:0] x, y, r, q;
    logic ci, sub, ar, be, sk, we;
    logic [8:0] s;
    logic [4:0] h;
    logic [3:0] nf;
    ar = 1'b1;
    sub = 1'b0;
    ci = 1'b0;
    x = a;
    y = b;
    nf = f;
    sk = 1'b0;
    case (op)
      flag_pkg::OP_ADD: ci = 1'b0;
      flag_pkg::OP_ADDC: ci = f[flag_pkg::FC];
      flag_pkg::OP_SUB, flag_pkg::OP_COMP, flag_pkg::OP_CEQSN,
      flag_pkg::OP_CNEQSN: sub = 1'b1;
      flag_pkg::OP_SUBC: begin
        sub = 1'b1;
        ci = f[flag_pkg::FC];
      end
      flag_pkg::OP_INC, flag_pkg::OP_IZSN: begin
        x = b;
        y = 8'h01;
      end
      flag_pkg::OP_DEC, flag_pkg::OP_DZSN: begin
        x = b;
        y = 8'h01;
        sub = 1'b1;
      end
      flag_pkg::OP_NADD: begin
        x = b;
        y = a;
        sub = 1'b1;
      end
      default: ar = 1'b0;
    endcase
    // subtract as x + ~y + ~borrow so carries turn into borrows
    if (sub) begin
      y = ~y;
      ci = ~ci;
    end
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    r = s[7:0];
    if (ar) nf = {(x[7] == y[7]) && (r[7] != x[7]), h[4] ^ sub,
        s[8] ^ sub, r == 8'h00};
    be = (op inside {flag_pkg::OP_BIT_SET, flag_pkg::OP_BIT_CLEAR,
        flag_pkg::OP_SKIP_LOW, flag_pkg::OP_SKIP_HIGH}) && i_bit_ram &&
        (i_bit_addr > flag_pkg::BIT_RAM_LAST);
    case (op)
      flag_pkg::OP_CEQSN, flag_pkg::OP_IZSN,
      flag_pkg::OP_DZSN: sk = (r == 8'h00);
      flag_pkg::OP_CNEQSN: sk = (r != 8'h00);
      flag_pkg::OP_SR, flag_pkg::OP_SRC: nf[flag_pkg::FC] = b[0];
      flag_pkg::OP_SL, flag_pkg::OP_SLC: nf[flag_pkg::FC] = b[7];
      flag_pkg::OP_AND: nf[flag_pkg::FZ] = (a & b) == 8'h00;
      flag_pkg::OP_OR: nf[flag_pkg::FZ] = (a | b) == 8'h00;
      flag_pkg::OP_XOR: nf[flag_pkg::FZ] = (a ^ b) == 8'h00;
      flag_pkg::OP_NOT: nf[flag_pkg::FZ] = b == 8'hff;
      flag_pkg::OP_NEG, flag_pkg::OP_LD_MEM:
        nf[flag_pkg::FZ] = b == 8'h00;
      flag_pkg::OP_POPAF: nf = i_pop_flags;
      flag_pkg::OP_SWAPC: nf[flag_pkg::FC] = i_io_bit;
      flag_pkg::OP_SKIP_LOW: sk = !be && !b[i_bit_sel];
      flag_pkg::OP_SKIP_HIGH: sk = !be && b[i_bit_sel];
      default: sk = 1'b0;
    endcase
    // write-back value and strobe of each class
    we = 1'b1;
    q = r;
    case (op)
      flag_pkg::OP_SR: q = b >> 1;
      flag_pkg::OP_SRC: q = {f[flag_pkg::FC], b[7:1]};
      flag_pkg::OP_SL: q = b << 1;
      flag_pkg::OP_SLC: q = {b[6:0], f[flag_pkg::FC]};
      flag_pkg::OP_AND: q = a & b;
      flag_pkg::OP_OR: q = a | b;
      flag_pkg::OP_XOR, flag_pkg::OP_XOR_IO: q = a ^ b;
      flag_pkg::OP_NOT: q = ~b;
      flag_pkg::OP_NEG: q = 8'h00 - b;
      flag_pkg::OP_LD_MEM, flag_pkg::OP_LD_IMM, flag_pkg::OP_STORE,
      flag_pkg::OP_XCH: q = b;
      flag_pkg::OP_CLEAR: q = 8'h00;
      flag_pkg::OP_SWAP: q = {a[3:0], a[7:4]};
      flag_pkg::OP_POPAF: q = i_pop_acc;
      flag_pkg::OP_BIT_SET: begin
        q = b | (8'h01 << i_bit_sel);
        we = !be;
      end
      flag_pkg::OP_BIT_CLEAR: begin
        q = b & ~(8'h01 << i_bit_sel);
        we = !be;
      end
      flag_pkg::OP_CEQSN, flag_pkg::OP_CNEQSN, flag_pkg::OP_COMP,
      flag_pkg::OP_PUSHAF, flag_pkg::OP_SWAPC, flag_pkg::OP_SKIP_LOW,
      flag_pkg::OP_SKIP_HIGH, flag_pkg::OP_NOP, flag_pkg::OP_CTRL,
      flag_pkg::OP_ENGINT, flag_pkg::OP_DISGINT,
      flag_pkg::OP_RETI: we = 1'b0;
      default: ;
    endcase
    return {we, q, be, sk, nf};
  endfunction : model

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // valid stays high between calls, so back-to-back issue every cycle
  task automatic exec(input flag_pkg::op_t op, input logic [7:0] a,
      input logic [7:0] b);
    logic [14:0] e;
    logic [3:0] f;
    f = exp_f;
    i_op = op;
    i_a = a;
    i_b = b;
    i_valid = 1'b1;
    e = model(op, a, b, f);
    @(posedge i_clk);
    #1;
    exp_f = e[3:0];
    chk({7'h00, o_push_valid, o_irq_take, o_result_we, o_bit_err, o_skip,
        o_flags}, {7'h00, op == flag_pkg::OP_PUSHAF, 1'b0, e[14],
        e[5:0]});
    if (e[14])
      chk({8'h00, o_result}, {8'h00, e[13:6]});
    if (op == flag_pkg::OP_PUSHAF)
      chk({3'h0, o_push_valid, o_push_data}, {4'h1, f, a});
    if (op == flag_pkg::OP_POPAF)
      chk({7'h00, o_result_we, o_result}, {8'h01, i_pop_acc});
    if (op == flag_pkg::OP_SWAPC)
      chk({15'h0000, o_io_bit}, {15'h0000, f[flag_pkg::FC]});
  endtask : exec

  task automatic nops(input int n);
    repeat (n) exec(flag_pkg::OP_NOP, 8'h00, 8'h00);
  endtask : nops

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_rstn, i_valid, i_bit_ram, i_io_bit, i_irq_req} = 5'h00;
    {i_a, i_b, i_bit_addr, i_pop_acc} = 32'h0000_0000;
    {i_bit_sel, i_pop_flags} = 7'h00;
    i_op = flag_pkg::OP_NOP;
    seed = 32'h0000_8392;
    err_count = 0;
    tests_run = 0;
    exp_f = flag_pkg::FLAGS_RST;
    repeat (4) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    chk({3'h0, o_gie, o_flags, o_result}, 16'h0000);
    // every class with corner operands; bit ops straddle 0x3f/0x40
    for (int k = 0; k < 5; k++) begin
      for (int n = 0; n < NOPS; n++) begin
        i_bit_ram = 1'b1;
        i_bit_addr = ((n + k) % 2 == 1) ? 8'h40 : 8'h3f;
        i_bit_sel = 3'(k);
        i_io_bit = n[1];
        i_pop_flags = 4'(n);
        i_pop_acc = 8'h5a;
        exec(flag_pkg::op_t'(6'(n)), ca[k], cb[k]);
      end
    end
    repeat (400) begin
      r1 = rnd();
      r2 = rnd();
      {i_bit_ram, i_io_bit, i_bit_sel} = r1[4:0];
      {i_bit_addr, i_pop_acc, i_pop_flags} = r1[31:12];
      exec(flag_pkg::op_t'(6'(r2[31:16] % NOPS)), r2[7:0], r2[15:8]);
    end
    // interrupt gate: enable, take, return, disable
    i_bit_ram = 1'b0;
    exec(flag_pkg::OP_DISGINT, 8'h00, 8'h00);
    nops(2);
    chk({15'h0000, o_gie}, 16'h0000);
    exec(flag_pkg::OP_ENGINT, 8'h00, 8'h00);
    nops(2);
    chk({15'h0000, o_gie}, 16'h0001);
    i_irq_req = 1'b1;
    i_op = flag_pkg::OP_ADD;
    i_a = 8'h80;
    i_b = 8'h80;
    @(posedge i_clk);
    #1;
    chk({11'h000, o_irq_take, o_flags}, {12'h001, exp_f});
    i_irq_req = 1'b0;
    nops(2);
    chk({15'h0000, o_gie}, 16'h0000);
    exec(flag_pkg::OP_PUSHAF, 8'hc3, 8'h00);
    i_pop_flags = 4'ha;
    i_pop_acc = 8'h3c;
    exec(flag_pkg::OP_POPAF, 8'h00, 8'h00);
    exec(flag_pkg::OP_RETI, 8'h00, 8'h00);
    nops(2);
    chk({15'h0000, o_gie}, 16'h0001);
    exec(flag_pkg::OP_DISGINT, 8'h00, 8'h00);
    nops(2);
    i_irq_req = 1'b1;
    exec(flag_pkg::OP_ADD, 8'h80, 8'h80);
    report_and_stop();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    report_and_stop();
  end
endmodule : alu_flag_update_test
`default_nettype wire
